/* rtl/emp_consts.svh */
// constants for the external memory address pin sharing block
// Behaviour
// [R1] With an 8-bit asynchronous memory the word address pins carry memory address 22..2 and the byte pins carry 1..0.
// [R2] With a 16-bit asynchronous memory the word address pins carry memory address 21..1 and the upper byte pin carries bit 0.
// [R3] Address pins 20 to 15 are each shared with one general I/O line, and only one function drives the pin at a time.
// [R4] Each shared pin has its own select bit in the external bus select register, switchable independently.
// [R5] During a NAND access, address pin 12 is the command latch strobe.
// [R6] During a NAND access, address pin 11 is the address latch strobe.
// [R7] The internal pulldown of each shared pin is enabled or disabled by a bit of pull disable register two.
// [R8] Address pins 14 to 10 are dedicated address bits, and only 12 and 11 take the NAND strobe roles.
// [R9] The device provides a 16-bit two-way data bus, driven on writes and sampled on reads.
// [R10] A shared pin selected for general I/O never shows the controller's address bit.
`ifndef EMP_CONSTS_SVH
`define EMP_CONSTS_SVH
`define EMP_ADDR_W 23
`define EMP_WORD_W 21
`define EMP_DATA_W 16
`define EMP_SHARED_LO 15
`define EMP_SHARED_N 6
`define EMP_CLE_BIT 11
`define EMP_ALE_BIT 10
`define EMP_CLE_PIN 12
`define EMP_ALE_PIN 11
`define EMP_REG_SEL 12'h000
`define EMP_REG_PULL 12'h004
`define EMP_REG_MODE 12'h008
`define EMP_REG_DIN 12'h00C
`define EMP_SEL_RST 6'h00
`define EMP_PULL_RST 6'h00
`endif

/* rtl/emp_pkg.sv */
// types for the external memory address pin sharing block
package emp_pkg;
  typedef enum logic [1:0] {
    EMP_MEM8 = 2'h1,
    EMP_MEM16 = 2'h2
  } emp_width_t;
endpackage : emp_pkg

/* rtl/emp_pin_share.sv */
// address path pin sharing with apb control registers
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "emp_consts.svh"
module emp_pin_share (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [22:0] mem_addr,
  input wire logic nand_cle,
  input wire logic nand_ale,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_write,
  output logic [15:0] mem_rdata,
  input wire logic [5:0] gpio_out,
  input wire logic [5:0] gpio_oe,
  output logic [5:0] gpio_in,
  output logic [20:0] ext_word_addr,
  output logic [20:0] ext_word_addr_oe,
  input wire logic [5:0] ext_word_addr_in,
  output logic [1:0] ext_byte_addr,
  output logic [15:0] ext_data_bus_out,
  output logic ext_data_bus_oe,
  input wire logic [15:0] ext_data_bus_in,
  output logic [5:0] internal_pulldown_en,
  output emp_pkg::emp_width_t width_mode
);
  import emp_pkg::*;

  logic [5:0] ext_bus_select_reg_q;
  logic [5:0] pull_disable_reg_two_q;
  logic nand_mode_q;
  logic [5:0] gin_s1_q, gin_s2_q;
  logic [15:0] din_s1_q, din_s2_q;
  logic [20:0] word_d;
  logic [1:0] byte_d;
  logic [20:0] word_q;
  logic [1:0] byte_q;
  logic [15:0] dout_q;
  logic doe_q;
  logic [5:0] goe_q, gout_q;
  logic wr_acc;
  logic rd_acc;
  emp_width_t width_q;

  // apb always ready, no wait states
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  // select register, one bit per shared pin
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ext_bus_select_reg_q <= `EMP_SEL_RST;
    end else if (wr_acc && paddr == `EMP_REG_SEL) begin
      ext_bus_select_reg_q <= pwdata[5:0]; // R4
    end
  end

  // pulldown disable register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pull_disable_reg_two_q <= `EMP_PULL_RST;
    end else if (wr_acc && paddr == `EMP_REG_PULL) begin
      pull_disable_reg_two_q <= pwdata[5:0]; // R7
    end
  end

  // memory width and nand mode
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      width_q <= EMP_MEM16;
      nand_mode_q <= 1'b0;
    end else if (wr_acc && paddr == `EMP_REG_MODE) begin
      width_q <= pwdata[0] ? EMP_MEM8 : EMP_MEM16;
      nand_mode_q <= pwdata[1];
    end
  end

  // read mux and error for unmapped addresses
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `EMP_REG_SEL) begin
        prdata <= {26'h0, ext_bus_select_reg_q};
      end else if (paddr == `EMP_REG_PULL) begin
        prdata <= {26'h0, pull_disable_reg_two_q};
      end else if (paddr == `EMP_REG_MODE) begin
        prdata <= {30'h0, nand_mode_q, width_q == EMP_MEM8};
      end else if (paddr == `EMP_REG_DIN) begin
        prdata <= {10'h0, gin_s2_q, din_s2_q};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end
  assign pslverr = psel && penable && !(paddr == `EMP_REG_SEL || paddr == `EMP_REG_PULL ||
                   paddr == `EMP_REG_MODE || paddr == `EMP_REG_DIN);

  // pin input synchronisers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gin_s1_q <= 6'h00;
      gin_s2_q <= 6'h00;
      din_s1_q <= 16'h0000;
      din_s2_q <= 16'h0000;
    end else begin
      gin_s1_q <= ext_word_addr_in;
      gin_s2_q <= gin_s1_q;
      din_s1_q <= ext_data_bus_in; // R9
      din_s2_q <= din_s1_q;
    end
  end
  assign gpio_in = gin_s2_q;
  assign mem_rdata = din_s2_q; // R9

  // address mapping by memory width, with nand strobes
  always_comb begin
    if (width_q == EMP_MEM8) begin
      word_d = mem_addr[22:2]; // R1
      byte_d = mem_addr[1:0]; // R1
    end else begin
      word_d = mem_addr[21:1]; // R2
      byte_d = {mem_addr[0], 1'b0}; // R2
    end
    if (nand_mode_q) begin
      word_d[`EMP_CLE_PIN] = nand_cle; // R5 R8
      word_d[`EMP_ALE_PIN] = nand_ale; // R6 R8
    end
  end

  // registered pin drivers, per shared pin mux
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      word_q <= 21'h00_0000;
      byte_q <= 2'h0;
      dout_q <= 16'h0000;
      doe_q <= 1'b0;
      gout_q <= 6'h00;
      goe_q <= 6'h00;
    end else begin
      word_q <= word_d;
      byte_q <= byte_d;
      dout_q <= mem_wdata;
      doe_q <= mem_write; // R9
      gout_q <= gpio_out;
      goe_q <= gpio_oe;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `EMP_WORD_W; gi = gi + 1) begin : g_pin
      if (gi >= `EMP_SHARED_LO) begin : g_shared
        // general io owns the pin when its select bit is set
        assign ext_word_addr[gi] = ext_bus_select_reg_q[gi-`EMP_SHARED_LO] ?
          gout_q[gi-`EMP_SHARED_LO] : word_q[gi]; // R3 R10
        assign ext_word_addr_oe[gi] = ext_bus_select_reg_q[gi-`EMP_SHARED_LO] ?
          goe_q[gi-`EMP_SHARED_LO] : 1'b1; // R3
      end else begin : g_dedicated
        assign ext_word_addr[gi] = word_q[gi]; // R8
        assign ext_word_addr_oe[gi] = 1'b1;
      end
    end
  endgenerate
  assign ext_byte_addr = byte_q;
  assign ext_data_bus_out = dout_q;
  assign ext_data_bus_oe = doe_q;
  assign internal_pulldown_en = ~pull_disable_reg_two_q; // R7
  assign width_mode = width_q;

  // checks
  sel_blocks_addr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ext_bus_select_reg_q[5] |-> ext_word_addr[20] == gout_q[5]) else $error("addr leaks on io pin"); // R10
  sel_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_acc && paddr == `EMP_REG_SEL |=> ext_bus_select_reg_q == $past(pwdata[5:0]))
    else $error("select write lost"); // R4
  map_eight_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    width_q == EMP_MEM8 && !nand_mode_q && $stable(width_q) |=> word_q == $past(mem_addr[22:2]))
    else $error("8-bit map wrong"); // R1
  byte_eight_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    width_q == EMP_MEM8 |=> byte_q == $past(mem_addr[1:0])) else $error("byte map wrong"); // R1
  map_sixteen_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    width_q == EMP_MEM16 |=> byte_q[1] == $past(mem_addr[0])) else $error("16-bit byte map wrong"); // R2
  cle_strobe_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    nand_mode_q && $stable(nand_mode_q) |=> ext_word_addr[12] == $past(nand_cle)) else $error("cle wrong"); // R5
  ale_strobe_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    nand_mode_q && $stable(nand_mode_q) |=> ext_word_addr[11] == $past(nand_ale)) else $error("ale wrong"); // R6
  pull_ctrl_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_acc && paddr == `EMP_REG_PULL |=> internal_pulldown_en == ~$past(pwdata[5:0]))
    else $error("pulldown control wrong"); // R7
  dedicated_pin_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ext_word_addr_oe[14:0] == 15'h7FFF) else $error("dedicated pin released"); // R8
  data_drive_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mem_write |=> ext_data_bus_oe && ext_data_bus_out == $past(mem_wdata)) else $error("data drive wrong"); // R9
  cov_gpio_c: cover property (@(posedge sys_clk) ext_bus_select_reg_q != 6'h00);
  cov_nand_c: cover property (@(posedge sys_clk) nand_mode_q && nand_cle);
  cov_eight_c: cover property (@(posedge sys_clk) width_q == EMP_MEM8 && mem_write);
endmodule : emp_pin_share
`default_nettype wire

/* verification/emp_mem_model.sv */
// external memory chip and shared pin level model
`timescale 1ns/1ps
`default_nettype none
module emp_mem_model (
  input wire logic sys_clk,
  input wire logic [20:0] ext_word_addr,
  input wire logic [20:0] ext_word_addr_oe,
  input wire logic [5:0] internal_pulldown_en,
  input wire logic [5:0] line_drive,
  input wire logic [15:0] ext_data_bus_out,
  input wire logic ext_data_bus_oe,
  output logic [5:0] ext_word_addr_in,
  output logic [15:0] ext_data_bus_in
);
  logic [15:0] mem_q [256];
  // shared pin: own driver, else pulldown, else outside driver
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      ext_word_addr_in[i] = ext_word_addr_oe[15+i] ? ext_word_addr[15+i] :
        (internal_pulldown_en[i] ? 1'b0 : line_drive[i]);
    end
  end
  // store what the device drives
  always @(posedge sys_clk) begin
    if (ext_data_bus_oe) begin
      mem_q[ext_word_addr[7:0]] <= ext_data_bus_out;
    end
  end
  // read data appears when the device lets go of the bus
  assign ext_data_bus_in = ext_data_bus_oe ? ext_data_bus_out : mem_q[ext_word_addr[7:0]];
endmodule : emp_mem_model
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the address pin sharing block
`timescale 1ns/1ps
`default_nettype none
`include "emp_consts.svh"
module testbench;
  import emp_pkg::*;
  logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic nand_cle = 0, nand_ale = 0, mem_write = 0, ext_data_bus_oe;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [22:0] mem_addr = 0;
  logic [15:0] mem_wdata = 0, mem_rdata, ext_data_bus_out, ext_data_bus_in;
  logic [5:0] gpio_out = 0, gpio_oe = 0, gpio_in, line_drive = 0, word_in, internal_pulldown_en, sel, pd;
  logic [20:0] ext_word_addr, ext_word_addr_oe;
  logic [1:0] ext_byte_addr, md = 0;
  emp_width_t width_mode;
  int mismatches = 0, checks_done = 0, seed = 37916;
  emp_pin_share dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
    .nand_cle(nand_cle), .nand_ale(nand_ale), .mem_wdata(mem_wdata), .mem_write(mem_write), .mem_rdata(mem_rdata),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in), .ext_word_addr(ext_word_addr),
    .ext_word_addr_oe(ext_word_addr_oe), .ext_word_addr_in(word_in), .ext_byte_addr(ext_byte_addr),
    .ext_data_bus_out(ext_data_bus_out), .ext_data_bus_oe(ext_data_bus_oe), .ext_data_bus_in(ext_data_bus_in),
    .internal_pulldown_en(internal_pulldown_en), .width_mode(width_mode));
  emp_mem_model mem_u (.sys_clk(sys_clk), .ext_word_addr(ext_word_addr), .ext_word_addr_oe(ext_word_addr_oe),
    .internal_pulldown_en(internal_pulldown_en), .line_drive(line_drive), .ext_data_bus_out(ext_data_bus_out),
    .ext_data_bus_oe(ext_data_bus_oe), .ext_word_addr_in(word_in), .ext_data_bus_in(ext_data_bus_in));
  // clock
  always #12.5 sys_clk = ~sys_clk;
  task automatic test_done;
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    // sample answer only at the rising edge where pready is seen high
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    if (n >= 20) begin
      mismatches++;
      test_done;
    end
    psel <= 0;
    penable <= 0;
  endtask : apb
  // settle, then compare every pin against the model
  task automatic pins(input logic [15:0] dv);
    logic [20:0] w, oe;
    logic [5:0] lv;
    logic [31:0] r;
    logic e;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    for (int i = 0; i < 21; i++) begin
      w[i] = md[0] ? mem_addr[i+2] : mem_addr[i+1];
      oe[i] = 1'b1;
    end
    if (md[1]) begin
      w[12] = nand_cle;
      w[11] = nand_ale;
    end
    for (int i = 0; i < 6; i++) begin
      if (sel[i]) begin
        w[15+i] = gpio_out[i];
        oe[15+i] = gpio_oe[i];
      end
      lv[i] = oe[15+i] ? w[15+i] : (pd[i] ? line_drive[i] : 1'b0);
    end
    chk("word", w, ext_word_addr);
    chk("word oe", oe, ext_word_addr_oe);
    chk("byte", md[0] ? mem_addr[1:0] : {mem_addr[0], 1'b0}, ext_byte_addr);
    chk("pulldown", {~pd}, internal_pulldown_en);
    chk("gpio in", lv, gpio_in);
    chk("bus", {mem_write, mem_wdata}, {ext_data_bus_oe, ext_data_bus_out});
    chk("rdata", dv, mem_rdata);
    chk("width", md[0] ? EMP_MEM8 : EMP_MEM16, width_mode);
    apb(0, `EMP_REG_DIN, 0, r, e);
    chk("din", {10'h0, lv, dv}, r);
  endtask : pins
  // main sequence
  initial begin
    logic [31:0] r;
    logic [15:0] wd;
    logic e;
    sel = 0;
    pd = 0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 0;
    apb(0, `EMP_REG_PULL, 0, r, e);
    chk("pull rst", `EMP_PULL_RST, r);
    apb(1, 12'h010, 32'hFFFFFFFF, r, e);
    chk("err", 1, e);
    apb(0, 12'h010, 0, r, e);
    chk("unmapped", 0, r);
    for (int k = 0; k < 14; k++) begin
      apb(0, `EMP_REG_SEL, 0, r, e);
      chk("sel", sel, r);
      sel = 6'($random(seed));
      pd = 6'($random(seed));
      md = 2'($random(seed));
      wd = 16'($random(seed));
      apb(1, `EMP_REG_SEL, {26'h0, sel}, r, e);
      apb(1, `EMP_REG_PULL, {26'h0, pd}, r, e);
      apb(1, `EMP_REG_MODE, {30'h0, md}, r, e);
      mem_addr <= 23'($random(seed));
      {nand_cle, nand_ale, gpio_out, gpio_oe, line_drive} <= 20'($random(seed));
      mem_wdata <= wd;
      mem_write <= 1;
      pins(wd);
      mem_write <= 0;
      pins(wd);
    end
    test_done;
  end
  // watchdog
  initial begin
    #500000;
    mismatches++;
    test_done;
  end
endmodule : testbench
`default_nettype wire
